//--- rtl/seep_pkg.sv
package seep_pkg;
	// Array geometry
	localparam int ADDR_W    = 10;
	localparam int PAGE_W    = 5;
	localparam int MEM_BYTES = 1024;
	localparam int PAGE_BYTES = 32;
	localparam logic [7:0] MEM_INIT    = 8'hFF;
	localparam logic [7:0] ERASED_BYTE = 8'h00;

	// Opcodes, sent MSB first
	localparam logic [7:0] OPC_NONE  = 8'h00;
	localparam logic [7:0] OPC_STAT_WR = 8'h01;
	localparam logic [7:0] OPC_WRITE = 8'h02;
	localparam logic [7:0] OPC_READ  = 8'h03;
	localparam logic [7:0] OPC_WRDI  = 8'h04;
	localparam logic [7:0] OPC_RDSR  = 8'h05;
	localparam logic [7:0] OPC_WR_EN = 8'h06;

	// Status byte field positions and reset values
	localparam int SB_LOCK   = 7;
	localparam int SB_PSZ_HI = 3;
	localparam int SB_PSZ_LO = 2;
	localparam int SB_WEN    = 1;
	localparam int SB_BUSY   = 0;
	localparam logic       LOCK_RST = 1'h0;
	localparam logic [1:0] BP_RST   = 2'h0;

	// Protected region starts
	localparam logic [ADDR_W-1:0] PROT_QTR  = 10'h300;
	localparam logic [ADDR_W-1:0] PROT_HALF = 10'h200;

	// Byte counts within a frame
	localparam logic [2:0] BIT_LAST      = 3'h7;
	localparam logic [2:0] NB_SAT        = 3'h7;
	localparam logic [2:0] NB_CMD        = 3'h1;
	localparam logic [2:0] NB_ADDR_FIRST = 3'h1;
	localparam logic [2:0] NB_ADDR_LAST  = 3'h2;
	localparam logic [2:0] NB_STAT_WR    = 3'h2;
	localparam logic [2:0] NB_WRITE_MIN  = 3'h4;
	localparam logic [PAGE_W-1:0] IDX_LAST = 5'h1F;

	// Self-timed cycle length
	localparam int unsigned CLK_NS = 4;
	localparam int unsigned PROG_NS = 5000000;
	localparam int unsigned PROG_CYCLES_DEF = PROG_NS / CLK_NS;

	// APB map
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam int   CTRL_EN      = 0;
	localparam logic CTRL_EN_RST  = 1'h1;
	localparam logic [3:0] SYNC_INIT = 4'h9;

	typedef enum logic [2:0] {
		FR_IDLE = 3'h0,
		FR_OPC  = 3'h1,
		FR_ADDR = 3'h3,
		FR_DATA = 3'h2,
		FR_READ = 3'h6,
		FR_STAT = 3'h7,
		FR_WAIT = 3'h5
	} seep_frame_t;

	typedef enum logic [1:0] {
		PG_IDLE  = 2'h0,
		PG_ERASE = 2'h1,
		PG_PROG  = 2'h3,
		PG_HOLD  = 2'h2
	} seep_prog_t;

	// Page base inside the block-protected region
	function automatic logic seep_protected(input logic [1:0] bp,
		input logic [ADDR_W-1:0] addr);
		case (bp)
			2'h1:    seep_protected = addr >= PROT_QTR;
			2'h2:    seep_protected = addr >= PROT_HALF;
			2'h3:    seep_protected = 1'h1;
			default: seep_protected = 1'h0;
		endcase
	endfunction

	// APB address decode
	function automatic logic seep_mapped(input logic [7:0] addr);
		seep_mapped = (addr == REG_STATUS) || (addr == REG_CTRL);
	endfunction
endpackage

//--- rtl/seep_sync.sv
`timescale 1ns/1ns
module seep_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// Two stages; only the second stage is read outside
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

//--- rtl/seep_array.sv
`timescale 1ns/1ns
module seep_array import seep_pkg::*; (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Write port
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [7:0]        wdata,
	// Read port
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [7:0]        rdata
);
	logic [7:0] mem_q [MEM_BYTES];

	// Reset stands in for the delivery state of the cells
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem_q[i] <= MEM_INIT;
			end
		end else if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	assign rdata = mem_q[raddr];

	array_write_a: assert property (@(posedge clk) disable iff (rst)
		we |=> mem_q[$past(waddr)] == $past(wdata))
		else $error("array byte not written");
endmodule

//--- rtl/seep_top.sv
`timescale 1ns/1ns
module seep_top import seep_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
	// System
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	// Serial link
	input  wire logic        SEL_N,
	input  wire logic        SCLK,
	input  wire logic        SDI,
	input  wire logic        GUARD_N,
	output logic             SDO,
	output logic             SDO_OE,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	logic              sel_s, sclk_s, sdi_s, guard_s;
	logic              sel_p_q, sclk_p_q;
	logic              sel_rise, sclk_rise, sclk_fall, byte_done, frame_end;
	seep_frame_t       fr_q;
	seep_prog_t        pg_q;
	logic [2:0]        bit_q, nbyte_q;
	logic [7:0]        sh_q, byte_v, cmd_q, stat_new_q, osh_q, stat_byte, rd_data;
	logic [1:0]        addr_hi_q, bp_q;
	logic [ADDR_W-1:0] ptr_q, addr_now, rd_addr;
	logic [7:0]        pbuf_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pmask_q;
	logic [PAGE_W-1:0] idx_q;
	logic [31:0]       ptime_q;
	logic              wen_q, lock_q, ctrl_en_q, pg_stat_q, busy, hard_prot, ptime_done, pg_end;
	logic              commit_stat, commit_arr, load_stat, load_mem, mem_we;
	logic [7:0]        mem_wdata;

	// Every pin from the link crosses into the system clock here
	seep_sync #(.W(4), .INIT(SYNC_INIT)) u_sync (
		.clk (CLK_SYS),
		.rst (RESET),
		.d   ({SEL_N, SCLK, SDI, GUARD_N}),
		.q   ({sel_s, sclk_s, sdi_s, guard_s})
	);

	// Edge history of the synchronised select and clock
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			sel_p_q  <= SYNC_INIT[3];
			sclk_p_q <= SYNC_INIT[2];
		end else begin
			sel_p_q  <= sel_s;
			sclk_p_q <= sclk_s;
		end
	end

	assign sel_rise  = sel_s & ~sel_p_q;
	assign sclk_rise = sclk_s & ~sclk_p_q & ~sel_s & (fr_q != FR_IDLE);
	assign sclk_fall = ~sclk_s & sclk_p_q & ~sel_s;
	assign byte_v    = {sh_q[6:0], sdi_s};
	assign byte_done = sclk_rise && (bit_q == BIT_LAST);
	assign frame_end = sel_rise && (fr_q != FR_IDLE);
	assign busy      = pg_q != PG_IDLE;
	assign hard_prot = lock_q & ~guard_s;
	assign addr_now  = {addr_hi_q, byte_v};
	assign rd_addr   = (fr_q == FR_ADDR) ? addr_now : ptr_q + 10'h001;

	// Frame state; a raised select always returns to idle
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			fr_q <= FR_IDLE;
		end else if (sel_s || !ctrl_en_q) begin
			fr_q <= FR_IDLE;
		end else if (fr_q == FR_IDLE) begin
			fr_q <= FR_OPC;
		end else if (byte_done) begin
			case (fr_q)
				FR_OPC: begin
					if (busy && byte_v != OPC_RDSR) begin
						fr_q <= FR_WAIT;
					end else begin
						case (byte_v)
							OPC_READ, OPC_WRITE: fr_q <= FR_ADDR;
							OPC_STAT_WR:         fr_q <= FR_DATA;
							OPC_RDSR:            fr_q <= FR_STAT;
							default:             fr_q <= FR_WAIT;
						endcase
					end
				end
				FR_ADDR: begin
					if (nbyte_q == NB_ADDR_LAST) begin
						fr_q <= (cmd_q == OPC_READ) ? FR_READ : FR_DATA;
					end
				end
				default: fr_q <= fr_q;
			endcase
		end
	end

	// Accepted opcode; a rejected one is remembered as none
	always_ff @(posedge CLK_SYS) begin
		if (RESET || fr_q == FR_IDLE) begin
			cmd_q <= OPC_NONE;
		end else if (byte_done && fr_q == FR_OPC) begin
			cmd_q <= (busy && byte_v != OPC_RDSR) ? OPC_NONE : byte_v;
		end
	end

	// Bit shifter and byte counter, counter saturates
	always_ff @(posedge CLK_SYS) begin
		if (RESET || fr_q == FR_IDLE) begin
			sh_q    <= 8'h00;
			bit_q   <= 3'h0;
			nbyte_q <= 3'h0;
		end else if (sclk_rise) begin
			sh_q  <= byte_v;
			bit_q <= bit_q + 3'h1;
			if (byte_done && nbyte_q != NB_SAT) begin
				nbyte_q <= nbyte_q + 3'h1;
			end
		end
	end

	// Address capture and pointer movement
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			addr_hi_q <= 2'h0;
			ptr_q     <= '0;
		end else if (byte_done) begin
			if (fr_q == FR_ADDR && nbyte_q == NB_ADDR_FIRST) begin
				addr_hi_q <= byte_v[1:0];
			end else if (fr_q == FR_ADDR) begin
				ptr_q <= addr_now;
			end else if (fr_q == FR_READ) begin
				ptr_q <= ptr_q + 10'h001;
			end else if (fr_q == FR_DATA && cmd_q == OPC_WRITE) begin
				// Only the in-page bits move, so a long burst overwrites its own page
				ptr_q[PAGE_W-1:0] <= ptr_q[PAGE_W-1:0] + 5'h01;
			end
		end
	end

	// Page buffer; mask cleared only when a new write is accepted
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pmask_q <= '0;
		end else if (byte_done && fr_q == FR_OPC && byte_v == OPC_WRITE && !busy) begin
			pmask_q <= '0;
		end else if (byte_done && fr_q == FR_DATA && cmd_q == OPC_WRITE) begin
			pbuf_q[ptr_q[PAGE_W-1:0]]  <= byte_v;
			pmask_q[ptr_q[PAGE_W-1:0]] <= 1'h1;
		end
	end

	// Pending status byte
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			stat_new_q <= 8'h00;
		end else if (byte_done && fr_q == FR_DATA && cmd_q == OPC_STAT_WR) begin
			stat_new_q <= byte_v;
		end
	end

	// End-of-frame checks that decide whether a cycle starts
	assign commit_stat = frame_end && cmd_q == OPC_STAT_WR && nbyte_q == NB_STAT_WR
		&& bit_q == 3'h0 && wen_q && !hard_prot;
	assign commit_arr = frame_end && cmd_q == OPC_WRITE && nbyte_q >= NB_WRITE_MIN
		&& bit_q == 3'h0 && wen_q
		&& !seep_protected(bp_q, {ptr_q[ADDR_W-1:PAGE_W], 5'h00});

	// Write enable latch
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			wen_q <= 1'h0;
		end else if (pg_end) begin
			wen_q <= 1'h0;
		end else if (frame_end && nbyte_q == NB_CMD && bit_q == 3'h0) begin
			if (cmd_q == OPC_WR_EN) begin
				wen_q <= 1'h1;
			end else if (cmd_q == OPC_WRDI) begin
				wen_q <= 1'h0;
			end
		end
	end

	assign ptime_done = ptime_q >= PROG_CYCLES - 1;
	assign pg_end     = (pg_q == PG_HOLD) && ptime_done;

	// Timed cycle: erase pass, program pass, then hold to full length; a status write goes straight to the hold
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pg_q      <= PG_IDLE;
			idx_q     <= '0;
			ptime_q   <= '0;
			pg_stat_q <= 1'h0;
		end else begin
			case (pg_q)
				PG_IDLE: begin
					ptime_q <= '0;
					idx_q <= '0;
					if (commit_arr) begin
						pg_q      <= PG_ERASE;
						pg_stat_q <= 1'h0;
					end else if (commit_stat) begin
						pg_q      <= PG_HOLD;
						pg_stat_q <= 1'h1;
					end
				end
				PG_ERASE: begin
					ptime_q <= ptime_q + 32'h1;
					idx_q   <= idx_q + 5'h01;
					if (idx_q == IDX_LAST) begin
						pg_q <= PG_PROG;
					end
				end
				PG_PROG: begin
					ptime_q <= ptime_q + 32'h1;
					idx_q   <= idx_q + 5'h01;
					if (idx_q == IDX_LAST) begin
						pg_q <= PG_HOLD;
					end
				end
				default: begin
					ptime_q <= ptime_q + 32'h1;
					if (ptime_done) begin
						pg_q <= PG_IDLE;
					end
				end
			endcase
		end
	end

	// Erased cells read as zeros, programming then sets the ones
	assign mem_we    = (pg_q == PG_ERASE || pg_q == PG_PROG) && pmask_q[idx_q];
	assign mem_wdata = (pg_q == PG_ERASE) ? ERASED_BYTE : pbuf_q[idx_q];

	seep_array u_array (
		.clk   (CLK_SYS),
		.rst   (RESET),
		.we    (mem_we),
		.waddr ({ptr_q[ADDR_W-1:PAGE_W], idx_q}),
		.wdata (mem_wdata),
		.raddr (rd_addr),
		.rdata (rd_data)
	);

	// Nonvolatile status bits change only when the cycle completes
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			lock_q <= LOCK_RST;
			bp_q   <= BP_RST;
		end else if (pg_end && pg_stat_q) begin
			lock_q <= stat_new_q[SB_LOCK];
			bp_q   <= stat_new_q[SB_PSZ_HI:SB_PSZ_LO];
		end
	end

	// Status byte; unused positions stay zero
	always_comb begin
		stat_byte          = 8'h00;
		stat_byte[SB_LOCK]   = lock_q;
		stat_byte[SB_PSZ_HI] = bp_q[1];
		stat_byte[SB_PSZ_LO] = bp_q[0];
		stat_byte[SB_WEN]    = wen_q;
		stat_byte[SB_BUSY]   = busy;
	end

	assign load_stat = (fr_q == FR_OPC && byte_v == OPC_RDSR) || fr_q == FR_STAT;
	assign load_mem  = (fr_q == FR_ADDR && nbyte_q == NB_ADDR_LAST && cmd_q == OPC_READ)
		|| fr_q == FR_READ;

	// Output shifter: load on the last rising edge, drive on falling edges
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			osh_q  <= 8'h00;
			SDO    <= 1'h0;
			SDO_OE <= 1'h0;
		end else if (fr_q == FR_IDLE) begin
			SDO_OE <= 1'h0;
		end else if (byte_done && (load_stat || load_mem)) begin
			osh_q <= load_stat ? stat_byte : rd_data;
		end else if (sclk_fall && (fr_q == FR_READ || fr_q == FR_STAT)) begin
			SDO    <= osh_q[7];
			osh_q  <= {osh_q[6:0], 1'h0};
			SDO_OE <= 1'h1;
		end
	end

	// APB: zero wait states, read data captured in the setup cycle
	assign PREADY  = 1'h1;
	assign PSLVERR = PSEL & PENABLE & ~seep_mapped(PADDR);

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			PRDATA <= 32'h0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == REG_STATUS) begin
				PRDATA <= {24'h0, stat_byte};
			end else if (PADDR == REG_CTRL) begin
				PRDATA <= {31'h0, ctrl_en_q};
			end else begin
				PRDATA <= 32'h0;
			end
		end
	end

	// Control register; a disabled device ignores select
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ctrl_en_q <= CTRL_EN_RST;
		end else if (PSEL && PENABLE && PWRITE && PADDR == REG_CTRL) begin
			ctrl_en_q <= PWDATA[CTRL_EN];
		end
	end

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	latch_gate_a: assert property ($rose(wen_q) |-> $past(frame_end && cmd_q == OPC_WR_EN))
		else $error("enable latch set without enable command");
	stat_frame_a: assert property ((pg_q == PG_IDLE) ##1 (pg_q == PG_HOLD)
		|-> $past(nbyte_q) == NB_STAT_WR && $past(bit_q) == 3'h0)
		else $error("status cycle from a bad frame");
	cycle_len_a: assert property ($fell(busy) |-> $past(ptime_q) >= PROG_CYCLES - 1)
		else $error("timed cycle too short");
	busy_flag_a: assert property (stat_byte[SB_BUSY] == (pg_q != PG_IDLE))
		else $error("busy flag wrong");
	latch_clear_a: assert property ($fell(busy) |-> !wen_q)
		else $error("latch not cleared after cycle");
	status_zero_a: assert property (stat_byte[6:4] == 3'h0)
		else $error("reserved status bits set");
	status_late_a: assert property (!pg_end |=> $stable(bp_q) && $stable(lock_q))
		else $error("status bits changed early");
	hard_block_a: assert property (hard_prot && sel_rise |-> !commit_stat)
		else $error("status write in hard protect");
	read_reject_a: assert property (busy && byte_done && fr_q == FR_OPC
		&& byte_v == OPC_READ |=> fr_q == FR_WAIT || fr_q == FR_IDLE)
		else $error("read accepted while busy");
	page_wrap_a: assert property (byte_done && fr_q == FR_DATA && cmd_q == OPC_WRITE
		|=> $stable(ptr_q[ADDR_W-1:PAGE_W]))
		else $error("write burst left its page");
	erase_first_a: assert property (pg_q == PG_PROG |-> $past(pg_q) != PG_IDLE)
		else $error("program without erase");
endmodule

//--- sim/seep_spim.sv
`timescale 1ns/1ns
module seep_spim (
	// System clock that paces the master
	input  wire logic CLK_SYS,
	// Serial link
	output logic      SEL_N,
	output logic      SCLK,
	output logic      SDI,
	input  wire logic SDO
);
	logic [7:0] tx_b [0:39];
	logic [7:0] rx_b [0:39];

	// Idle: deselected, clock parked low outside frames
	initial begin
		SEL_N = 1'b1;
		SCLK  = 1'b0;
		SDI   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask

	// Mode 0 frame of nb bytes plus nx loose bits, 32 ns link period
	// SDO is taken as the clock falls: it holds a few cycles past that fall
	task automatic frame(input int nb, input int nx);
		int i;
		int b;
		tick(1);
		SEL_N <= 1'b0;
		tick(3);
		for (i = 0; i < nb + (nx > 0 ? 1 : 0); i++) begin
			for (b = 7; b >= (i < nb ? 0 : 8 - nx); b--) begin
				SDI <= tx_b[i][b];
				tick(4);
				SCLK <= 1'b1;
				tick(4);
				SCLK <= 1'b0;
				rx_b[i][b] = SDO;
			end
		end
		tick(2);
		// Select rises after the last latching edge, before any further one
		SEL_N <= 1'b1;
		SDI   <= ~SDI;
		tick(6);
	endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ns
module tb import seep_pkg::*; ;
	// Long enough that a four-byte frame fits inside one cycle
	localparam int PROG_LEN = 400;
	// {guard, opcode, byte1, byte2, bytes, loose bits}
	localparam logic [39:0] DIR [0:15] = '{
		40'h1018C00020, 40'h1060000010, 40'h101FF00020, 40'h0060000010,
		40'h0010000020, 40'h1060000010, 40'h1010000020, 40'h0060000010,
		40'h0010400020, 40'h0060000010, 40'h0020300050, 40'h002FCFE270,
		40'h0060000010, 40'h0020040053, 40'h00300E0230, 40'h003FFFE065};
	logic        CLK_SYS = 1'b0;
	logic        RESET   = 1'b1;
	logic        GUARD_N = 1'b1;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [7:0]  PADDR   = 8'h00;
	logic [31:0] PWDATA  = 32'h0;
	wire         SEL_N, SCLK, SDI, SDO, SDO_OE, PREADY, PSLVERR;
	wire  [31:0] PRDATA;
	integer      seed    = 32'hEAC4D7E9;
	integer      n_fail  = 0;
	integer      n_checks = 0;
	logic [7:0]  m_mem [0:1023];
	logic        m_lock  = 1'b0;
	logic        m_wen   = 1'b0;
	logic        m_en    = 1'b1;
	logic [1:0]  m_bp    = 2'h0;
	logic        oe_seen = 1'b0;

	always #2 CLK_SYS = ~CLK_SYS;

	// Remember any cycle in which the device drove its output
	always @(posedge CLK_SYS) begin
		if (SDO_OE === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end

	seep_top #(.PROG_CYCLES(PROG_LEN)) u_seep_top (.CLK_SYS(CLK_SYS), .RESET(RESET), .SEL_N(SEL_N),
		.SCLK(SCLK), .SDI(SDI), .GUARD_N(GUARD_N), .SDO(SDO), .SDO_OE(SDO_OE), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR));
	seep_spim u_seep_spim (.CLK_SYS(CLK_SYS), .SEL_N(SEL_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO));

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; a dead slave is caught by the watchdog, not here
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge CLK_SYS);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= wd;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK_SYS);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic st_rd(output logic [7:0] s);
		logic [31:0] d;
		logic        e;
		apb(1'b0, REG_STATUS, 32'h0, d, e);
		s = d[7:0];
	endtask

	function automatic logic [7:0] m_st(input logic busy);
		return {m_lock, 3'h0, m_bp, m_wen, busy};
	endfunction

	function automatic logic prot(input logic [9:0] a);
		return m_bp == 2'h3 || (m_bp == 2'h2 && a >= 10'h200) || (m_bp == 2'h1 && a >= 10'h300);
	endfunction

	// Send the frame in tx_b, predict its effect, then follow any timed cycle
	task automatic cmd(input int nb, input int nx);
		logic [7:0] op;
		logic [9:0] a;
		logic [7:0] s;
		logic       go;
		int         k;
		op = u_seep_spim.tx_b[0];
		a = {u_seep_spim.tx_b[1][1:0], u_seep_spim.tx_b[2]};
		oe_seen = 1'b0;
		u_seep_spim.frame(nb, nx);
		chk("drive after select", 32'h0, SDO_OE);
		chk("read drive", m_en && op == 8'h03 && nb >= 3, oe_seen);
		for (k = 3; k < nb && op == 8'h03 && m_en; k++) begin
			chk("read byte", m_mem[10'(a + k - 3)], u_seep_spim.rx_b[k]);
		end
		go = m_en && nx == 0 && m_wen && ((op == 8'h01 && nb == 2 && !(m_lock && !GUARD_N))
			|| (op == 8'h02 && nb > 3 && !prot(a)));
		if (m_en && nx == 0 && nb == 1 && (op == 8'h04 || op == 8'h06)) begin
			m_wen = op[1];
		end
		st_rd(s);
		chk("status", m_st(go), s);
		if (go) begin
			if (op == 8'h01) begin
				m_lock = u_seep_spim.tx_b[1][7];
				m_bp = u_seep_spim.tx_b[1][3:2];
			end
			for (k = 3; k < nb && op == 8'h02; k++) begin
				m_mem[{a[9:5], 5'(a[4:0] + k - 3)}] = u_seep_spim.tx_b[k];
			end
			m_wen = 1'b0;
			// A read or write sent while busy must be dropped
			u_seep_spim.tx_b[0] = 8'h02 | 8'($random(seed) & 1);
			oe_seen = 1'b0;
			u_seep_spim.frame(4, 0);
			chk("busy drive", 32'h0, oe_seen);
			st_rd(s);
			chk("busy held", 32'h1, s[0]);
			k = 0;
			do begin
				st_rd(s);
				k++;
			end while (s[0] !== 1'b0 && k < PROG_LEN);
			st_rd(s);
			chk("status done", m_st(1'b0), s);
		end
	endtask

	// Watchdog sized well past the expected run
	initial begin
		#400000;
		n_fail++;
		$display("timeout");
		test_done();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] r;
		logic        e;
		int          it;
		int          k;
		int          nb;
		int          nx;
		for (k = 0; k < 1024; k++) begin
			m_mem[k] = 8'hFF;
		end
		for (k = 0; k < 40; k++) begin
			u_seep_spim.tx_b[k] = 8'($random(seed));
		end
		repeat (2) @(posedge CLK_SYS);
		RESET <= 1'b0;
		// Register bus: reset values, read-only status, unmapped place
		apb(1'b0, REG_STATUS, 32'h0, d, e);
		chk("status reset", 32'h0, d);
		apb(1'b0, REG_CTRL, 32'h0, d, e);
		chk("ctrl reset", 32'h1, d);
		apb(1'b1, 8'h10, 32'hFFFFFFFF, d, e);
		chk("unmapped error", 32'h1, e);
		apb(1'b1, REG_STATUS, 32'hFF, d, e);
		apb(1'b0, 8'h10, 32'h0, d, e);
		chk("unmapped data", 32'h0, d);
		$display("register test done");
		// Directed protection, wrap and abort cases
		for (it = 0; it < 16; it++) begin
			GUARD_N <= DIR[it][36];
			{u_seep_spim.tx_b[0], u_seep_spim.tx_b[1], u_seep_spim.tx_b[2]} = DIR[it][35:12];
			cmd(int'(DIR[it][11:4]), int'(DIR[it][3:0]));
		end
		$display("directed test done");
		// Disabled device ignores select
		apb(1'b1, REG_CTRL, 32'h0, d, e);
		m_en = 1'b0;
		u_seep_spim.tx_b[0] = 8'h06;
		cmd(1, 0);
		u_seep_spim.tx_b[0] = 8'h03;
		cmd(5, 0);
		apb(1'b1, REG_CTRL, 32'h1, d, e);
		m_en = 1'b1;
		$display("enable test done");
		// Random mix of commands, lengths, aborts and guard levels
		for (it = 0; it < 30; it++) begin
			r = $random(seed);
			GUARD_N <= r[0];
			for (k = 0; k < 40; k++) begin
				u_seep_spim.tx_b[k] = 8'($random(seed));
			end
			nx = (r[3:1] == 3'h0) ? 1 + r[6:4] % 7 : 0;
			case (r[10:8])
				3'h0, 3'h1: begin
					u_seep_spim.tx_b[0] = {6'h01, r[11] | r[12], 1'b0};
					nb = 1;
					nx = 0;
				end
				3'h2: begin
					u_seep_spim.tx_b[0] = 8'h01;
					nb = 1 + r[12:11];
				end
				3'h3, 3'h4: begin
					u_seep_spim.tx_b[0] = 8'h02;
					nb = 3 + r[16:11] % 37;
				end
				3'h5: begin
					u_seep_spim.tx_b[0] = 8'h03;
					nb = 3 + r[14:12];
					u_seep_spim.tx_b[2] = r[17] ? 8'hFD : u_seep_spim.tx_b[2];
				end
				default: begin
					u_seep_spim.tx_b[0] = {3'h1, r[15:11]};
					nb = 1 + r[12:11];
				end
			endcase
			cmd(nb, nx);
		end
		$display("random test done");
		test_done();
	end
endmodule
